// file: design/spi_pkg.sv
// Purpose: shared constants and types of the serial peripheral port
// Assumes: 40 MHz sys_clk, one byte shifted per transfer
// Notes:   rate codes map onto sys_clk dividers, never faster than f/4
package spi_pkg;

  // rate select codes, {rate_select_high, rate_select_low}
  localparam logic [1:0] RATE_F4  = 2'h0;
  localparam logic [1:0] RATE_F8  = 2'h1;
  localparam logic [1:0] RATE_F32 = 2'h2;
  localparam logic [1:0] RATE_F64 = 2'h3;

  // shift clock period in sys_clk cycles for each code
  localparam logic [6:0] DIV_F4  = 7'h04;
  localparam logic [6:0] DIV_F8  = 7'h08;
  localparam logic [6:0] DIV_F32 = 7'h20;
  localparam logic [6:0] DIV_F64 = 7'h40;

  // bit slots at the start of a transfer that show the load window
  localparam int LOAD_WINDOW_SLOTS = 4;

  // reset values
  localparam logic [5:0] RATE_CNT_RESET = 6'h00;
  localparam logic       FLAG_RESET     = 1'b0;

  // transfer engine phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT,
    PH_RUN
  } phase_type;

endpackage : spi_pkg

// file: design/spi_rate_if.sv
// Purpose: carries rate choice and bit slot ticks between engine and divider
// Assumes: single sys_clk domain
// Notes:   ticks are one-cycle pulses from flip-flops
`timescale 1ns/1ps
interface spi_rate_if;
  logic [1:0] rate_sel;
  logic       half_tick;
  logic       slot_tick;

  modport gen  (input rate_sel, output half_tick, output slot_tick);
  modport user (output rate_sel, input half_tick, input slot_tick);
endinterface : spi_rate_if

// file: design/spi_rate_gen.sv
// Purpose: free-running divider giving half-bit and full-bit slot ticks
// Assumes: rate_sel may change at any time; counter wraps cleanly
// Notes:   slot_tick marks a bit slot boundary, half_tick each sck edge
`timescale 1ns/1ps
module spi_rate_gen (
  input wire logic   sys_clk,
  input wire logic   rstn,
  spi_rate_if.gen    port
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       half_tick;
    logic       slot_tick;
  } rate_state_type;

  rate_state_type q, d;
  logic [6:0]     div;
  logic [5:0]     last;
  logic [5:0]     mid;

  // divider for the selected code
  function automatic logic [6:0] rate_div(input logic [1:0] sel);
    unique case (sel)
      spi_pkg::RATE_F4:  rate_div = spi_pkg::DIV_F4;
      spi_pkg::RATE_F8:  rate_div = spi_pkg::DIV_F8;
      spi_pkg::RATE_F32: rate_div = spi_pkg::DIV_F32;
      spi_pkg::RATE_F64: rate_div = spi_pkg::DIV_F64;
    endcase
  endfunction : rate_div

  // count one shift clock period, tick at its middle and its end
  always_comb begin
    div = rate_div(port.rate_sel);
    last = 6'(div - 7'h01);
    mid = 6'((div >> 1) - 7'h01);
    d = q;
    d.cnt = (q.cnt >= last) ? 6'h00 : 6'(q.cnt + 6'h01);
    d.half_tick = (q.cnt == mid) || (q.cnt >= last);
    d.slot_tick = (q.cnt >= last);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{cnt: spi_pkg::RATE_CNT_RESET, half_tick: 1'b0, slot_tick: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign port.half_tick = q.half_tick;
  assign port.slot_tick = q.slot_tick;

endmodule : spi_rate_gen

// file: design/spi_master_slave_buffered.sv
// Purpose: full-duplex byte serial port, master or slave, normal/enhanced
// Assumes: all pins synchronous to sys_clk; slave sck well below f/4
// Notes:   pins split into in/out/oe; outputs all come from flip-flops
// How it works
// - sck output as master, input as slave
// - master_select sets data pin directions
// - master ignores slave select pin
// - slave active only while select is low
// - master data write starts clock and shifting
// - master start waits for next bit slot
// - after byte: stop, done flag, read buffer
// - interrupt needs both enables set
// - one data address: read buffer, write path
// - normal write while busy: collision, byte dropped
// - enhanced write while busy loads holding buffer, flags full
// - full flag clears when held byte loads
// - enhanced write when idle starts at once
// - load window flag over first four slots
// - held byte at completion continues without stopping
// - shift clock never above f/4
// - receive always buffered, transmit only enhanced
// - wake request only in slave operation
// - rate code picks f/4, f/8, f/32, f/64
// - bit order selects lsb or msb first
// - polarity sets shift clock idle level
// - unreloaded slave echoes last received byte
`timescale 1ns/1ps
module spi_master_slave_buffered #(
  parameter int DATA_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              spi_enable,
  input  wire logic              master_select,
  input  wire logic              enhanced_mode,
  input  wire logic              bit_order_select,
  input  wire logic              clk_polarity,
  input  wire logic              clk_phase,
  input  wire logic              rate_select_high,
  input  wire logic              rate_select_low,
  input  wire logic              spi_irq_enable,
  input  wire logic              serial_port_irq_enable,
  input  wire logic              data_write,
  input  wire logic [DATA_W-1:0] data_write_value,
  input  wire logic              done_clear,
  input  wire logic              collision_clear,
  input  wire logic              sck_in,
  input  wire logic              mosi_in,
  input  wire logic              miso_in,
  input  wire logic              ss_n_in,
  output logic [DATA_W-1:0]      spi_data_buffer,
  output logic                   transfer_done_flag,
  output logic                   collision_buffer_full_flag,
  output logic                   load_window_flag,
  output logic                   irq_req,
  output logic                   wake_req,
  output logic                   sck_out,
  output logic                   sck_oe,
  output logic                   mosi_out,
  output logic                   mosi_oe,
  output logic                   miso_out,
  output logic                   miso_oe
);

  localparam int EDGES = 2 * DATA_W;
  localparam int CW    = $clog2(EDGES + 1); // room for the window count too
  localparam logic [CW-1:0] LAST_EDGE = CW'(EDGES - 1);
  localparam logic [CW-1:0] WIN_EDGES = CW'(2 * spi_pkg::LOAD_WINDOW_SLOTS);

  generate
    if (DATA_W < 4 || DATA_W > 32) begin : g_bad_width
      $error("DATA_W must lie between 4 and 32");
    end
  endgenerate

  typedef struct packed {
    spi_pkg::phase_type ph;
    logic [DATA_W-1:0]  sh;
    logic [DATA_W-1:0]  hold;
    logic [DATA_W-1:0]  rd;
    logic [CW-1:0]      edges;
    logic               rx_bit;
    logic               dout;
    logic               sck;
    logic               sck_prev;
    logic               done;
    logic               coll;
    logic               lw;
    logic               irq;
    logic               wake;
    logic               sck_oe;
    logic               mosi_oe;
    logic               miso_oe;
  } port_state_type;

  port_state_type q, d;
  spi_rate_if     rif ();
  logic           busy;
  logic           ev;
  logic           lead;
  logic           in_bit;
  logic           comp;
  logic           slave_sel;

  // bit presented on the data line for the chosen order
  function automatic logic out_bit(input logic [DATA_W-1:0] s,
                                   input logic              lsb_first);
    out_bit = lsb_first ? s[0] : s[DATA_W-1];
  endfunction : out_bit

  // shift one received bit in, opposite end to the one going out
  function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] s,
                                                 input logic b,
                                                 input logic lsb_first);
    shift_in = lsb_first ? {b, s[DATA_W-1:1]} : {s[DATA_W-2:0], b};
  endfunction : shift_in

  assign rif.rate_sel = {rate_select_high, rate_select_low};

  spi_rate_gen u_rate (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .port    (rif.gen)
  );

  // transfer engine, flags and pin control
  always_comb begin
    d = q;
    ev = 1'b0;
    lead = 1'b0;
    comp = 1'b0;
    slave_sel = spi_enable && !master_select && !ss_n_in;
    busy = (q.ph != spi_pkg::PH_IDLE);
    in_bit = master_select ? miso_in : mosi_in;
    d.sck_prev = sck_in;
    // software clears first so hardware sets below win
    if (done_clear) begin
      d.done = 1'b0;
    end
    if (collision_clear) begin
      d.coll = 1'b0;
    end
    // shift clock edges: own divider as master, pin as slave
    if (master_select && q.ph == spi_pkg::PH_RUN && rif.half_tick) begin
      ev = 1'b1;
      lead = !q.edges[0];
      d.sck = !q.sck;
    end else if (!master_select && slave_sel && sck_in != q.sck_prev) begin
      ev = 1'b1;
      lead = (sck_in != clk_polarity);
      d.ph = spi_pkg::PH_RUN;
    end
    if (master_select && q.ph == spi_pkg::PH_WAIT && rif.slot_tick) begin
      d.ph = spi_pkg::PH_RUN;
      d.edges = '0;
    end
    // sample and shift on the edges chosen by the phase control
    if (ev) begin
      if (lead) begin
        if (clk_phase) begin
          d.dout = out_bit(q.sh, bit_order_select);
        end else begin
          d.rx_bit = in_bit;
        end
      end else begin
        d.sh = shift_in(q.sh, clk_phase ? in_bit : q.rx_bit,
                        bit_order_select);
        if (!clk_phase) begin
          d.dout = out_bit(d.sh, bit_order_select);
        end
      end
      d.edges = CW'(q.edges + 1'b1);
      if (q.edges == LAST_EDGE) begin
        comp = 1'b1;
      end
    end
    // end of byte: receive buffer loads, possibly chain the held byte
    if (comp) begin
      d.rd = d.sh;
      d.done = 1'b1;
      d.edges = '0;
      if (enhanced_mode && q.coll) begin
        d.sh = q.hold;
        d.coll = 1'b0;
        d.ph = spi_pkg::PH_RUN;
        d.dout = out_bit(q.hold, bit_order_select);
      end else begin
        d.ph = spi_pkg::PH_IDLE;
      end
    end
    // deselected slave drops any partial byte
    if (!master_select && !slave_sel) begin
      d.ph = spi_pkg::PH_IDLE;
      d.edges = '0;
    end
    // data register write path
    if (data_write && spi_enable) begin
      if (busy && !enhanced_mode) begin
        d.coll = 1'b1;
      end else if (busy) begin
        d.hold = data_write_value;
        d.coll = 1'b1;
      end else begin
        d.sh = data_write_value;
        d.edges = '0;
        if (enhanced_mode) begin
          d.coll = 1'b0;
        end
        if (master_select) begin
          d.ph = spi_pkg::PH_WAIT;
        end
      end
    end
    if (!spi_enable) begin
      d.ph = spi_pkg::PH_IDLE;
      d.edges = '0;
    end
    // idle line levels
    if (d.ph != spi_pkg::PH_RUN) begin
      d.sck = clk_polarity;
      d.dout = out_bit(d.sh, bit_order_select);
    end
    d.lw = (d.ph == spi_pkg::PH_RUN) && (d.edges < WIN_EDGES);
    d.irq = d.done && spi_irq_enable && serial_port_irq_enable;
    d.wake = d.done && spi_enable && !master_select;
    d.sck_oe = spi_enable && master_select;
    d.mosi_oe = spi_enable && master_select;
    d.miso_oe = slave_sel;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{ph: spi_pkg::PH_IDLE, sh: '0, hold: '0, rd: '0, edges: '0,
             rx_bit: 1'b0, dout: 1'b0, sck: 1'b0, sck_prev: 1'b0,
             done: spi_pkg::FLAG_RESET, coll: spi_pkg::FLAG_RESET,
             lw: 1'b0, irq: 1'b0, wake: 1'b0, sck_oe: 1'b0,
             mosi_oe: 1'b0, miso_oe: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flip-flops
  assign spi_data_buffer            = q.rd;
  assign transfer_done_flag         = q.done;
  assign collision_buffer_full_flag = q.coll;
  assign load_window_flag           = q.lw;
  assign irq_req                    = q.irq;
  assign wake_req                   = q.wake;
  assign sck_out                    = q.sck;
  assign sck_oe                     = q.sck_oe;
  assign mosi_out                   = q.dout;
  assign mosi_oe                    = q.mosi_oe;
  assign miso_out                   = q.dout;
  assign miso_oe                    = q.miso_oe;

  // checks on the engine
  chk_sck_drive_dir: assert property (@(posedge sys_clk) disable iff (!rstn)
    spi_enable && master_select |=> sck_oe && mosi_oe && !miso_oe)
    else $error("master does not drive sck and mosi");
  chk_slave_pins: assert property (@(posedge sys_clk) disable iff (!rstn)
    spi_enable && !master_select && !ss_n_in |=> miso_oe && !sck_oe)
    else $error("selected slave pin directions wrong");
  chk_slave_deselect: assert property (@(posedge sys_clk) disable iff (!rstn)
    !master_select && ss_n_in |=> q.ph == spi_pkg::PH_IDLE && !miso_oe)
    else $error("deselected slave still active");
  chk_start_slot: assert property (@(posedge sys_clk) disable iff (!rstn)
    master_select && spi_enable && q.ph == spi_pkg::PH_WAIT && !rif.slot_tick
    |=> q.ph == spi_pkg::PH_WAIT && $stable(sck_out))
    else $error("master clocked before bit slot");
  chk_norm_collide: assert property (@(posedge sys_clk) disable iff (!rstn)
    data_write && spi_enable && !enhanced_mode && busy
    |=> collision_buffer_full_flag && $stable(q.hold))
    else $error("normal mode collision not flagged");
  chk_enh_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    data_write && spi_enable && enhanced_mode && busy
    |=> collision_buffer_full_flag && q.hold == $past(data_write_value))
    else $error("enhanced write not held");
  chk_enh_idle_go: assert property (@(posedge sys_clk) disable iff (!rstn)
    data_write && spi_enable && enhanced_mode && !busy && master_select
    |=> !collision_buffer_full_flag && q.ph == spi_pkg::PH_WAIT)
    else $error("idle enhanced write did not start");
  chk_done_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
    comp && !(enhanced_mode && q.coll) && !data_write
    |=> transfer_done_flag && q.ph == spi_pkg::PH_IDLE
        && spi_data_buffer == $past(d.sh))
    else $error("completion did not stop and flag");
  chk_chain: assert property (@(posedge sys_clk) disable iff (!rstn)
    comp && enhanced_mode && q.coll && !data_write && master_select
    |=> q.ph == spi_pkg::PH_RUN && !collision_buffer_full_flag
        && q.sh == $past(q.hold))
    else $error("held byte not chained");
  chk_window_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(q.ph == spi_pkg::PH_RUN) |-> load_window_flag)
    else $error("load window missing at transfer start");
  chk_sck_rate: assert property (@(posedge sys_clk) disable iff (!rstn)
    master_select && $changed(sck_out) |=> $stable(sck_out))
    else $error("shift clock faster than f/4");
  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    irq_req |-> $past(spi_irq_enable && serial_port_irq_enable))
    else $error("interrupt without both enables");

endmodule : spi_master_slave_buffered

// file: test/spi_slave_model.sv
// Purpose: behavioural far-side slave facing the port in master mode
// Assumes: shift clock seen on sys_clk, edges at least two cycles apart
// Notes:   outside a frame miso toggles every cycle, never holds a bit
`timescale 1ns/1ps
module spi_slave_model (
  input  wire logic       sys_clk,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            miso
);
  logic       sck_q;
  logic       junk_q = 1'b0;
  logic [3:0] e_q;
  logic [3:0] idx;

  // edge detection, capture on sample edges, count shift edges
  always @(posedge sys_clk) begin
    sck_q  <= sck;
    junk_q <= ~junk_q;
    if (load) begin
      e_q <= 4'h0;
    end else if (!sel_n && sck != sck_q) begin
      if ((sck_q == cpol) ^ cpha) begin
        rx_byte <= lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      end else begin
        e_q <= e_q + 4'h1;
      end
    end
  end

  // out bit picked by shift edge count, junk when not in a frame
  assign idx  = cpha ? e_q - 4'h1 : e_q;
  assign miso = (sel_n || (cpha && e_q == 4'h0)) ? junk_q
              : tx_byte[lsb ? idx[2:0] : 3'h7 - idx[2:0]];
endmodule : spi_slave_model

// file: test/spi_master_slave_buffered_test.sv
// Purpose: self-checking bench for the serial port, master and slave
// Assumes: slave model on the far side while the port is master
// Notes:   bench plays the master itself while the port is slave
`timescale 1ns/1ps
module spi_master_slave_buffered_test;
  logic sys_clk = 1'b0, rstn, spi_enable, master_select, enhanced_mode;
  logic bit_order_select, clk_polarity, clk_phase, rate_select_high;
  logic rate_select_low, spi_irq_enable, serial_port_irq_enable;
  logic data_write, done_clear, collision_clear, sck_in, mosi_in;
  logic miso_in, ss_n_in, sck_out, sck_oe, mosi_out, mosi_oe, miso_out;
  logic miso_oe, irq_req, wake_req, transfer_done_flag, load_window_flag;
  logic collision_buffer_full_flag, m_ld, m_sel_n, mon_clr, sck_p;
  logic [7:0] data_write_value, spi_data_buffer, m_tx, m_rx, got;
  logic [6:0] divs [4] = '{spi_pkg::DIV_F4, spi_pkg::DIV_F8,
                           spi_pkg::DIV_F32, spi_pkg::DIV_F64};
  // {polarity, phase, lsb first, rate code}
  logic [4:0] cfgs [4] = '{5'h00, 5'h0d, 5'h16, 5'h1b};
  int failures = 0, n_checks = 0, cyc = 0, togs, t_first, t_last, lw_cnt;

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  spi_master_slave_buffered dut_u (.*);

  spi_slave_model m_u (.sys_clk(sys_clk), .sck(sck_out), .mosi(mosi_out),
    .sel_n(m_sel_n), .cpol(clk_polarity), .cpha(clk_phase),
    .lsb(bit_order_select), .load(m_ld), .tx_byte(m_tx), .rx_byte(m_rx),
    .miso(miso_in));

  // counts shift clock toggles and load window cycles of a transfer
  always @(posedge sys_clk) begin
    cyc   <= cyc + 1;
    sck_p <= sck_out;
    if (mon_clr) begin
      togs   <= 0;
      lw_cnt <= 0;
    end else begin
      if (sck_oe && sck_out !== sck_p) begin
        if (togs == 0) t_first <= cyc;
        t_last <= cyc;
        togs   <= togs + 1;
      end
      if (load_window_flag) lw_cnt <= lw_cnt + 1;
    end
  end

  task automatic test_done();
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] v);
    data_write       <= 1'b1;
    data_write_value <= v;
    @(posedge sys_clk);
    data_write <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // bounded wait for the load window (lw=1) or the done flag
  task automatic wait_sig(input bit lw);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge sys_clk);
      if ((lw ? load_window_flag : transfer_done_flag) === 1'b1) break;
    end
    if (k == 3000) begin
      failures++;
      test_done();
    end
  endtask : wait_sig

  task automatic clr_done();
    done_clear <= 1'b1;
    @(posedge sys_clk);
    done_clear <= 1'b0;
    @(posedge sys_clk);
  endtask : clr_done

  task automatic mload(input logic [7:0] sv);
    m_tx    <= sv;
    m_ld    <= 1'b1;
    mon_clr <= 1'b1;
    @(posedge sys_clk);
    m_ld    <= 1'b0;
    mon_clr <= 1'b0;
  endtask : mload

  // one master byte against the model, with timing and flag checks
  task automatic mxfer(input logic [7:0] wv, input logic [7:0] sv,
                       input int d);
    int t_w;
    mload(sv);
    t_w = cyc;
    wr(wv);
    wait_sig(0);
    // last toggle and last model sample land one edge after the flag
    @(posedge sys_clk);
    chk_val(16'(togs), 16'h0010);
    chk_val(16'(t_last - t_first), 16'(15 * d / 2));
    chk_bit(t_first - t_w <= d + d / 2 + 4, 1'b1);
    chk_bit(lw_cnt >= 4 * d - 2 && lw_cnt <= 4 * d + 2, 1'b1);
    chk_val(16'(spi_data_buffer), 16'(sv));
    chk_val(16'(m_rx), 16'(wv));
    chk_bit(irq_req, spi_irq_enable & serial_port_irq_enable);
    chk_bit(wake_req, 1'b0);
    clr_done();
  endtask : mxfer

  // bench acts as master, mode 0, msb first, eight cycles a half bit
  task automatic sxfer(input logic [7:0] mo);
    ss_n_in <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_bit(miso_oe & ~mosi_oe, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= mo[i];
      repeat (8) @(posedge sys_clk);
      got[i] = miso_out;
      sck_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      sck_in <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    ss_n_in <= 1'b1;
    mosi_in <= ~mo[0];
    @(posedge sys_clk);
    chk_bit(transfer_done_flag, 1'b1);
  endtask : sxfer

  // main sequence
  initial begin
    {rstn, spi_enable, enhanced_mode, clk_polarity, clk_phase} = '0;
    {rate_select_high, rate_select_low, bit_order_select, data_write} = '0;
    {done_clear, collision_clear, sck_in, mosi_in, m_ld, m_sel_n} = '0;
    {master_select, ss_n_in, spi_irq_enable, serial_port_irq_enable} = '1;
    {mon_clr, data_write_value, m_tx} = '0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk_bit(transfer_done_flag | collision_buffer_full_flag, 1'b0);
    for (int i = 0; i < 4; i++) begin
      spi_enable <= 1'b0;
      {clk_polarity, clk_phase, bit_order_select, rate_select_high,
       rate_select_low} <= cfgs[i];
      serial_port_irq_enable <= (i != 1);
      ss_n_in <= i[0];
      @(posedge sys_clk);
      spi_enable <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk_bit(sck_out, cfgs[i][4]);
      chk_bit(sck_oe & mosi_oe & ~miso_oe, 1'b1);
      mxfer(8'h81 ^ 8'(i * 37), 8'h6c ^ 8'(i * 91), int'(divs[i]));
    end
    // normal mode write while busy
    {clk_polarity, clk_phase, bit_order_select, rate_select_high,
     rate_select_low} <= 5'h01;
    // let the idle level settle before the model counts edges
    @(posedge sys_clk);
    mload(8'h3c);
    wr(8'ha5);
    repeat (10) @(posedge sys_clk);
    wr(8'h0f);
    chk_bit(collision_buffer_full_flag, 1'b1);
    wait_sig(0);
    @(posedge sys_clk);
    chk_val(16'(m_rx), 16'h00a5);
    chk_val(16'(togs), 16'h0010);
    chk_val(16'(spi_data_buffer), 16'h003c);
    clr_done();
    // enhanced mode chained bytes
    enhanced_mode <= 1'b1;
    mload(8'h96);
    wr(8'hc3);
    chk_bit(collision_buffer_full_flag, 1'b0);
    wait_sig(1);
    wr(8'h11);
    chk_bit(collision_buffer_full_flag, 1'b1);
    collision_clear <= 1'b1;
    @(posedge sys_clk);
    collision_clear <= 1'b0;
    @(posedge sys_clk);
    chk_bit(collision_buffer_full_flag, 1'b0);
    wr(8'he7);
    wait_sig(0);
    chk_val(16'(m_rx), 16'h00c3);
    chk_bit(collision_buffer_full_flag, 1'b0);
    chk_val(16'(spi_data_buffer), 16'h0096);
    clr_done();
    wait_sig(0);
    @(posedge sys_clk);
    chk_val(16'(m_rx), 16'h00e7);
    chk_val(16'(togs), 16'h0020);
    chk_val(16'(t_last - t_first), 16'h007c);
    clr_done();
    // slave mode
    spi_enable <= 1'b0;
    {master_select, enhanced_mode, m_sel_n} <= 3'h1;
    {clk_polarity, clk_phase, bit_order_select, rate_select_high,
     rate_select_low} <= 5'h00;
    @(posedge sys_clk);
    spi_enable <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_bit(sck_oe | mosi_oe, 1'b0);
    wr(8'h5a);
    for (int i = 0; i < 8; i++) begin
      sck_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sck_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    chk_bit(transfer_done_flag, 1'b0);
    sxfer(8'hc6);
    chk_val(16'(got), 16'h005a);
    chk_val(16'(spi_data_buffer), 16'h00c6);
    @(posedge sys_clk);
    chk_bit(wake_req, 1'b1);
    clr_done();
    sxfer(8'h21);
    chk_val(16'(got), 16'h00c6);
    chk_val(16'(spi_data_buffer), 16'h0021);
    test_done();
  end
endmodule : spi_master_slave_buffered_test
